// ===== led_breathe_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module led_breathe_asserts
    import led_breathe_pkg::*;
(
    // Clock and reset.
    input wire logic        clk,
    input wire logic        rstn,
    // Register bus.
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    // Unit side and lamp.
    input wire logic        resume_from_sleep,
    input wire logic        led_out,
    input wire logic        duty_step_q
);
    logic        take;
    logic        ctl_wr;
    logic [1:0]  mode_q;
    logic [10:0] gap_q;
    assign take   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign ctl_wr = take && wb_we_i && wb_adr_i == unit_control_off && wb_sel_i[0];
    always_ff @(posedge clk or negedge rstn)
        if (!rstn) mode_q <= 2'h0;
        else if (ctl_wr) mode_q <= wb_dat_i[1:0];
    // A resume or sync may realign the ramp, so spacing is only judged between plain steps.
    always_ff @(posedge clk or negedge rstn)
        if (!rstn) gap_q <= 11'h7ff;
        else if (resume_from_sleep || (ctl_wr && wb_dat_i[5])) gap_q <= 11'h7ff;
        else if (duty_step_q) gap_q <= 11'h0;
        else if (gap_q != 11'h7ff) gap_q <= gap_q + 11'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_ack_answer: assert property (take |=> wb_ack_o || wb_err_o)
        else $error("bus request not answered one cycle later");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_err_unmapped: assert property (take && !(wb_adr_i inside {8'h10, 8'h14, 8'h18, 8'h1c})
        |=> wb_err_o && !wb_ack_o) else $error("unmapped access not refused");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_skew_reserved: assert property (
        take && !wb_we_i && wb_adr_i == turn_on_skew_off |=> wb_dat_o[31:8] == 24'h0)
        else $error("reserved skew bits not zero");
    a_step_spacing: assert property (duty_step_q |-> gap_q >= 11'h3ff)
        else $error("duty steps closer than one period");
    a_off_dark: assert property ((mode_q == mode_off)[*4] |-> !led_out)
        else $error("lamp lit in off mode");
    a_on_lit: assert property ((mode_q == mode_on)[*4] |-> led_out)
        else $error("lamp dark in on mode");
endmodule // led_breathe_asserts
bind led_breathe_interval_and_skew led_breathe_asserts i_chk (.clk, .rstn, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
    .resume_from_sleep, .led_out, .duty_step_q);
`default_nettype wire

// ===== led_breathe_interval_and_skew.sv
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module led_breathe_interval_and_skew
    import led_breathe_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // Unit side.
    input  wire logic        descending_phase_flag,
    input  wire logic        resume_from_sleep,
    // Lamp pin and step strobe.
    output logic             led_out,
    output logic             duty_step_q,
    output logic      [7:0]  duty_q_o
);

    logic [31:0] interval_shadow_q;
    logic [31:0] interval_work_q;
    logic [7:0]  skew_shadow_q;
    logic [7:0]  skew_work_q;
    lamp_setup_s setup_q;
    logic        sync_q;
    logic        enable_seen_q;
    logic [7:0]  pwm_cnt_q;
    logic [7:0]  duty_q;
    logic        up_q;
    logic [3:0]  wait_q;
    logic [11:0] div_q;
    logic        tick;
    logic        period_end;
    logic [2:0]  seg;
    logic [3:0]  cur_interval;
    logic        live;
    logic        restart;
    logic        bypass;
    logic        wr;
    logic        rd_hit;
    logic [31:0] rd_data;
    logic        ack_d;
    logic        led_d;

    // Bus decode; one wait state, answer after the cycle the strobe is seen.
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o;

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h0000_0000;
        unique case (wb_adr_i)
            ramp_update_interval_off: rd_data = interval_work_q;
            turn_on_skew_off:         rd_data = {24'h00_0000, skew_work_q};
            unit_control_off:         rd_data = {26'h000_0000, sync_q, setup_q.commit_en,
                                                 setup_q.tick_sel, setup_q.symmetric,
                                                 setup_q.mode};
            unit_status_off:          rd_data = {22'h00_0000, wait_q, live, up_q,
                                                 seg, led_out};
            default:                  rd_hit  = 1'b0;
        endcase
    end

    assign ack_d = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= ack_d && rd_hit;
            wb_err_o <= ack_d && !rd_hit;
            wb_dat_o <= (ack_d && rd_hit && !wb_we_i) ? rd_data : 32'h0000_0000;
        end
    end

    // Shadow copies accept writes at any time, byte by byte.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            interval_shadow_q <= interval_reset;
            skew_shadow_q     <= skew_reset;
        end else if (wr) begin
            if (wb_adr_i == ramp_update_interval_off) begin
                for (int b = 0; b < 4; b++) begin
                    if (wb_sel_i[b]) begin
                        interval_shadow_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
                    end
                end
            end
            if (wb_adr_i == turn_on_skew_off && wb_sel_i[0]) begin
                skew_shadow_q <= wb_dat_i[skew_lsb +: skew_w];
            end
        end
    end

    // Control register; sync bit clears itself once acted on.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            setup_q <= '{mode: mode_off, symmetric: 1'b0, tick_sel: 1'b0, commit_en: 1'b0};
            sync_q  <= 1'b0;
        end else if (wr && wb_adr_i == unit_control_off && wb_sel_i[0]) begin
            setup_q.mode      <= lamp_mode_e'(wb_dat_i[ctl_mode_lsb +: 2]);
            setup_q.symmetric <= wb_dat_i[ctl_shape_bit];
            setup_q.tick_sel  <= wb_dat_i[ctl_tick_bit];
            setup_q.commit_en <= wb_dat_i[ctl_commit_bit];
            sync_q            <= wb_dat_i[ctl_sync_bit];
        end else begin
            sync_q <= 1'b0;
        end
    end

    // Working copies move only at a PWM period boundary.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            interval_work_q <= interval_reset;
            skew_work_q     <= skew_reset;
        end else if (period_end && setup_q.commit_en) begin
            interval_work_q <= interval_shadow_q;
            skew_work_q     <= skew_shadow_q;
        end
    end

    // Tick divider; the select picks the fast or the 32 kHz-like rate.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_q <= 12'h000;
        end else if (tick) begin
            div_q <= 12'h000;
        end else begin
            div_q <= div_q + 12'h001;
        end
    end

    assign tick = setup_q.tick_sel ? (div_q == 12'(slow_tick_div - 1))
                                   : (div_q == 12'(fast_tick_div - 1));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwm_cnt_q <= 8'h00;
        end else if (tick) begin
            pwm_cnt_q <= pwm_cnt_q + 8'h01;
        end
    end

    assign period_end = tick && (pwm_cnt_q == pwm_last);

    // Segment selector and interval lookup.
    assign seg          = seg_index(setup_q.symmetric, descending_phase_flag, duty_q);
    assign cur_interval = interval_work_q[interval_field_w*seg +: interval_field_w];

    // Update spacing: n+1 periods between duty steps.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_q      <= 4'h0;
            duty_step_q <= 1'b0;
        end else if (period_end) begin
            if (wait_q >= cur_interval) begin
                wait_q      <= 4'h0;
                duty_step_q <= 1'b1;
            end else begin
                wait_q      <= wait_q + 4'h1;
                duty_step_q <= 1'b0;
            end
        end else begin
            duty_step_q <= 1'b0;
        end
    end

    // Simple unit-step triangle ramp so the intervals are exercised.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            duty_q <= 8'h00;
            up_q   <= 1'b1;
        end else if (duty_step_q && setup_q.mode == mode_breathe) begin
            if (up_q) begin
                duty_q <= duty_q + 8'h01;
                up_q   <= (duty_q != 8'hfe);
            end else begin
                duty_q <= duty_q - 8'h01;
                up_q   <= (duty_q == 8'h01);
            end
        end
    end

    // Turn-on skew: restart at each enable from off, resume, or sync.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            enable_seen_q <= 1'b0;
        end else begin
            enable_seen_q <= (setup_q.mode != mode_off);
        end
    end

    assign restart = (setup_q.mode != mode_off && !enable_seen_q)
                   || resume_from_sleep || sync_q;
    assign bypass  = (setup_q.mode == mode_on) || (setup_q.mode == mode_off);

    skew_delay u_skew (
        .clk        (clk),
        .rstn       (rstn),
        .tick       (tick),
        .restart    (restart),
        .bypass     (bypass),
        .skew_count (skew_work_q),
        .live       (live)
    );

    always_comb begin
        led_d = 1'b0;
        unique case (setup_q.mode)
            mode_off:     led_d = 1'b0;
            mode_on:      led_d = 1'b1;
            mode_breathe: led_d = live && (pwm_cnt_q < duty_q);
            mode_blink:   led_d = live && pwm_cnt_q[7];
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            led_out  <= 1'b0;
            duty_q_o <= 8'h00;
        end else begin
            led_out  <= led_d;
            duty_q_o <= duty_q;
        end
    end

endmodule // led_breathe_interval_and_skew
`default_nettype wire

// ===== led_breathe_interval_and_skew_bench.sv
`timescale 1ns/1ns
`default_nettype none
module led_breathe_interval_and_skew_bench;
    import led_breathe_pkg::*;
    logic        clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, fall = 0, resume = 0;
    logic [7:0]  adr = '0, duty;
    logic [3:0]  sel = '0;
    logic [31:0] wdat = '0, rdat, iv, rd;
    logic        ack, err, led, step, e;
    logic [7:0]  d0;
    int          lit, fail_count = 0, total_checks = 0, cycles = 0, s, a, b, g;
    led_breathe_interval_and_skew i_dut (.clk, .rstn, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .descending_phase_flag(fall),
        .resume_from_sleep(resume), .led_out(led), .duty_step_q(step), .duty_q_o(duty));
    led_load i_load (.clk, .rstn, .led_out(led), .lit);
    always #5 clk = ~clk;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Classic single cycle; released only after the edge that samples the answer.
    // A slave that never answers is caught by the cycle ceiling, not here.
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1; stb <= 1; we <= w; adr <= ad; wdat <= d; sel <= 4'hf;
        do begin
            @(posedge clk);
        end while (!(ack || err));
        rd = rdat;
        e = err;
        cyc <= 0; stb <= 0;
    endtask
    function automatic logic [31:0] ctl(lamp_mode_e m, logic sym, logic cm, logic sy);
        return {26'h0, sy, cm, 1'b0, sym, m};
    endfunction
    function automatic int gap(int n);
        return (n + 1) * 256 * fast_tick_div;
    endfunction
    task automatic wait_step(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!step && n < 40000);
    endtask
    task automatic skew_live(input int dly, input logic exp);
        repeat (dly) @(posedge clk);
        bus(0, unit_status_off, 0);
        chk(rd[5], exp);
    endtask
    initial begin
        void'($urandom(32'hc0c0));
        repeat (4) @(posedge clk);
        rstn <= 1;
        bus(0, ramp_update_interval_off, 0); chk(rd, interval_reset);
        bus(0, turn_on_skew_off, 0); chk(rd, 32'h0);
        bus(1, 8'h40, 32'h1234_5678); chk(e, 1'b1);
        a = $urandom_range(7); b = $urandom_range(7); s = $urandom_range(255, 8);
        iv = $urandom; iv[3:0] = 4'(a); iv[19:16] = 4'(b);
        bus(1, ramp_update_interval_off, iv);
        bus(1, turn_on_skew_off, {24'($urandom), 8'(s)});
        bus(1, unit_control_off, ctl(mode_breathe, 1, 0, 0));
        wait_step(g); wait_step(g);
        bus(0, ramp_update_interval_off, 0); chk(rd, 32'h0);
        bus(1, unit_control_off, ctl(mode_breathe, 1, 1, 0));
        wait_step(g);
        bus(0, ramp_update_interval_off, 0); chk(rd, iv);
        bus(0, turn_on_skew_off, 0); chk(rd, {24'h0, 8'(s)});
        repeat (2) wait_step(g);
        d0 = duty;
        wait_step(g);
        chk(g, gap(a));
        chk(duty, 32'(d0) + 32'h1);
        fall <= 1;
        bus(1, unit_control_off, ctl(mode_breathe, 0, 1, 0));
        repeat (3) wait_step(g);
        chk(g, gap(b));
        for (int t = 0; t < 3; t++) begin
            if (t == 0) begin
                @(posedge clk) resume <= 1;
                @(posedge clk) resume <= 0;
            end else if (t == 1) bus(1, unit_control_off, ctl(mode_breathe, 0, 1, 1));
            else begin
                bus(1, unit_control_off, ctl(mode_off, 0, 1, 0));
                bus(1, unit_control_off, ctl(mode_breathe, 0, 1, 0));
            end
            skew_live(s * fast_tick_div - 20, 1'b0);
            skew_live(40, 1'b1);
        end
        bus(1, turn_on_skew_off, 0);
        wait_step(g);
        @(posedge clk) resume <= 1;
        @(posedge clk) resume <= 0;
        skew_live(6, 1'b1);
        // A small count keeps the slow-tick skew run short.
        bus(1, turn_on_skew_off, 32'h0000_0002);
        wait_step(g);
        bus(1, unit_control_off, ctl(mode_on, 0, 1, 0));
        repeat (8) @(posedge clk);
        chk(led, 1'b1);
        chk(lit > 0, 1'b1);
        bus(1, unit_control_off, ctl(mode_breathe, 0, 1, 1) | (32'h0000_0001 << ctl_tick_bit));
        skew_live(2900, 1'b0);
        skew_live(3400, 1'b1);
        rstn <= 0;
        repeat (4) @(posedge clk);
        rstn <= 1;
        bus(0, ramp_update_interval_off, 0); chk(rd, interval_reset);
        bus(0, turn_on_skew_off, 0); chk(rd, 32'h0);
        end_of_test();
    end
endmodule // led_breathe_interval_and_skew_bench
`default_nettype wire

// ===== led_breathe_pkg.sv
`default_nettype none
package led_breathe_pkg;

    // Register byte offsets.
    localparam logic [7:0] ramp_update_interval_off = 8'h10;
    localparam logic [7:0] turn_on_skew_off         = 8'h14;
    localparam logic [7:0] unit_control_off         = 8'h18;
    localparam logic [7:0] unit_status_off          = 8'h1c;

    // Reset values.
    localparam logic [31:0] interval_reset = 32'h0000_0000;
    localparam logic [7:0]  skew_reset     = 8'h00;

    // Field layout.
    localparam int interval_field_w = 4;
    localparam int skew_lsb         = 0;
    localparam int skew_w           = 8;

    // Control register bit positions.
    localparam int ctl_mode_lsb   = 0;   // Two bits of lamp mode.
    localparam int ctl_shape_bit  = 2;   // Ramp shape select, 1 = symmetric.
    localparam int ctl_tick_bit   = 3;   // Tick source select.
    localparam int ctl_commit_bit = 4;   // Shadow commit enable.
    localparam int ctl_sync_bit   = 5;   // Realign outputs, self clearing.

    // Lamp modes.
    typedef enum logic [1:0] {
        mode_off     = 2'b00,
        mode_breathe = 2'b01,
        mode_blink   = 2'b10,
        mode_on      = 2'b11
    } lamp_mode_e;

    // Tick rates, as clock division counts.
    localparam int fast_tick_div = 4;
    localparam int slow_tick_hz  = 32768;
    localparam int clk_hz        = 100_000_000;
    localparam int slow_tick_div = clk_hz / slow_tick_hz;

    // PWM counter wrap defines the PWM period boundary.
    localparam logic [7:0] pwm_last = 8'hff;

    typedef struct packed {
        lamp_mode_e mode;
        logic       symmetric;
        logic       tick_sel;
        logic       commit_en;
    } lamp_setup_s;

    // Turn-on skew states.
    typedef enum logic [2:0] {
        sk_idle  = 3'b001,
        sk_count = 3'b010,
        sk_live  = 3'b100
    } skew_state_e;

    function automatic logic [2:0] seg_index(input logic symmetric,
                                             input logic falling,
                                             input logic [7:0] duty);
        seg_index = symmetric ? duty[7:5] : {falling, duty[7:6]};
    endfunction

endpackage
`default_nettype wire

// ===== led_load.sv
`timescale 1ns/1ns
`default_nettype none
module led_load (
    // Clock, reset and pin.
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic led_out,
    // Time the lamp has been lit.
    output int        lit
);
    always_ff @(posedge clk or negedge rstn)
        if (!rstn) lit <= 0;
        else if (led_out) lit <= lit + 1;
endmodule // led_load
`default_nettype wire

// ===== skew_delay.sv
`timescale 1ns/1ns
`default_nettype none
module skew_delay
    import led_breathe_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rstn,
    // Control.
    input  wire logic       tick,
    input  wire logic       restart,
    input  wire logic       bypass,
    input  wire logic [7:0] skew_count,
    // Gate to the output stage.
    output logic            live
);

    skew_state_e state_q;
    logic [7:0]  cnt_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= sk_idle;
            cnt_q   <= 8'h00;
        end else if (restart) begin
            state_q <= sk_count;
            cnt_q   <= 8'h00;
        end else begin
            unique case (state_q)
                sk_idle: begin
                    state_q <= sk_idle;
                end
                sk_count: begin
                    if (bypass || skew_count == 8'h00 || cnt_q == skew_count) begin
                        state_q <= sk_live;
                    end else if (tick) begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                sk_live: begin
                    state_q <= sk_live;
                end
            endcase
        end
    end

    assign live = (state_q == sk_live) || bypass;

endmodule // skew_delay
`default_nettype wire
